// [shared/dsp_slice_pkg.sv]
/*
 * Constants shared by the multiply-add slice: operand widths, clock source
 * selection codes, configuration codes and stage reset values.
 * Assumes the surrounding fabric logic runs on the same clock as the slice.
 */
// Functional notes
// - Product-only mode presents A times B with no adder stage.
// - Input, pipeline and output stages each optional; latency follows the choice.
// - Four-product mode: A0*B0 plus or minus A1*B1.
// - Four-product mode: A2*B2 plus or minus A3*B3.
// - Both pair results are summed and presented as the result.
// - Four-product stages can be enabled individually.
// - Signedness may change every cycle; applies to that cycle's operands.
// - Add or subtract may change every cycle, honoured per cycle.
// - A operands load in parallel or serially, selectable; B operands always load in parallel.
// - Each stage ticks on one of four fabric clock sources.
// - Clock enable and reset from routing reach every stage.
`default_nettype none
package dsp_slice_pkg;
	localparam int OPERAND_A_WIDTH = 18;
	localparam int OPERAND_B_WIDTH = 18;
	localparam int LANE_COUNT = 4;
	localparam int CLK_SEL_WIDTH = 2;
	localparam logic [1:0] SEL_FABRIC_CLOCK_0 = 2'h0;
	localparam logic [1:0] SEL_FABRIC_CLOCK_1 = 2'h1;
	localparam logic [1:0] SEL_FABRIC_CLOCK_2 = 2'h2;
	localparam logic [1:0] SEL_FABRIC_CLOCK_3 = 2'h3;
	localparam logic MODE_PRODUCT_ONLY = 1'b0;
	localparam logic MODE_FOUR_PRODUCT = 1'b1;
	localparam logic LOAD_PARALLEL = 1'b0;
	localparam logic LOAD_SERIAL = 1'b1;
	localparam logic ADDSUB_ADD = 1'b0;
	localparam logic STAGE_RESET_VALUE = 1'b0;
endpackage
`default_nettype wire

// [core/dsp_stage_reg.sv]
/*
 * One optional register stage of the slice: register or bypass, with its
 * own clock-source selection, clock enable and synchronous routing reset.
 * Assumes the four clock sources are one-cycle enable ticks on clk.
 */
`default_nettype none
module dsp_stage_reg #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic stage_en,
	input wire logic [dsp_slice_pkg::CLK_SEL_WIDTH-1:0] clk_sel,
	input wire logic [3:0] tick_src,
	input wire logic ce,
	input wire logic srst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	import dsp_slice_pkg::*;
	logic [WIDTH-1:0] hold_reg;
	logic [WIDTH-1:0] hold_next;
	wire tick_sel = tick_src[clk_sel];
	wire load = tick_sel & ce;

	assign hold_next = srst ? {WIDTH{STAGE_RESET_VALUE}} : (load ? d : hold_reg);
	assign q = stage_en ? hold_reg : d;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			hold_reg <= '0;
		else
			hold_reg <= hold_next;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	stage_clear_a: assert property (srst |=> hold_reg == '0) else $error("stage not cleared");
	stage_load_a: assert property (!srst && tick_src[clk_sel] && ce |=> hold_reg == $past(d))
		else $error("stage missed load");
	stage_hold_a: assert property (!srst && !(tick_src[clk_sel] && ce) |=> $stable(hold_reg))
		else $error("stage changed without tick");
	stage_bypass_a: assert property (!stage_en |-> q == d) else $error("bypass not transparent");
endmodule // dsp_stage_reg
`default_nettype wire

// [core/dsp_multiply_add_slice.sv]
/*
 * Configurable multiply or four-product multiply-add-sum slice with optional
 * input, pipeline and output stages, each on a selectable fabric clock tick.
 * Assumes all operands, controls and ticks come from logic on clk.
 */
`default_nettype none
module dsp_multiply_add_slice #(
	parameter int A_W = dsp_slice_pkg::OPERAND_A_WIDTH,
	parameter int B_W = dsp_slice_pkg::OPERAND_B_WIDTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic mode_sel,
	input wire logic load_sel,
	input wire logic [dsp_slice_pkg::LANE_COUNT-1:0][A_W-1:0] operand_a,
	input wire logic [dsp_slice_pkg::LANE_COUNT-1:0][B_W-1:0] operand_b,
	input wire logic [A_W-1:0] serial_a_in,
	input wire logic signed_a,
	input wire logic signed_b,
	input wire logic addsub_lo,
	input wire logic addsub_hi,
	input wire logic in_stage_en,
	input wire logic pipe_stage_en,
	input wire logic out_stage_en,
	input wire logic [dsp_slice_pkg::CLK_SEL_WIDTH-1:0] in_clk_sel,
	input wire logic [dsp_slice_pkg::CLK_SEL_WIDTH-1:0] pipe_clk_sel,
	input wire logic [dsp_slice_pkg::CLK_SEL_WIDTH-1:0] out_clk_sel,
	input wire logic fabric_clock_source_0,
	input wire logic fabric_clock_source_1,
	input wire logic fabric_clock_source_2,
	input wire logic fabric_clock_source_3,
	input wire logic stage_ce,
	input wire logic stage_srst,
	output logic [A_W+B_W+1:0] result_reg,
	output logic [A_W-1:0] serial_a_out_reg
);
	import dsp_slice_pkg::*;
	localparam int P_W = A_W + B_W;
	localparam int S_W = P_W + 2;
	localparam int IN_W = LANE_COUNT * (A_W + B_W) + 5;
	localparam int PIPE_W = LANE_COUNT * P_W + 4;

	logic [3:0] tick_src;
	logic [LANE_COUNT-1:0][A_W-1:0] lane_a;
	logic [LANE_COUNT-1:0][A_W-1:0] op_a;
	logic [LANE_COUNT-1:0][B_W-1:0] op_b;
	logic [LANE_COUNT-1:0][P_W-1:0] prod;
	logic [LANE_COUNT-1:0][P_W-1:0] pp_prod;
	logic [IN_W-1:0] in_q;
	logic [PIPE_W-1:0] pipe_q;
	logic [S_W-1:0] out_q;
	logic op_sa, op_sb, op_as_lo, op_as_hi, op_mode;
	logic pp_sg, pp_as_lo, pp_as_hi, pp_mode;
	logic [S_W-1:0] pair_lo, pair_hi, sum_next, ext0, ext1, ext2, ext3;

	assign tick_src = {fabric_clock_source_3, fabric_clock_source_2, fabric_clock_source_1, fabric_clock_source_0};

	// In serial load the A operands form a shift chain through the input stage,
	// so serial loading only advances when the input stage is enabled.
	assign lane_a[0] = (load_sel == LOAD_SERIAL) ? serial_a_in : operand_a[0];
	genvar gi;
	generate
		for (gi = 1; gi < LANE_COUNT; gi++)
		begin : g_chain
			assign lane_a[gi] = (load_sel == LOAD_SERIAL) ? op_a[gi-1] : operand_a[gi];
		end
	endgenerate

	// Controls travel with the operands so each cycle keeps its own choice.
	dsp_stage_reg #(.WIDTH(IN_W)) u_in_stage (
		.clk(clk),
		.rst_b(rst_b),
		.stage_en(in_stage_en),
		.clk_sel(in_clk_sel),
		.tick_src(tick_src),
		.ce(stage_ce),
		.srst(stage_srst),
		.d({mode_sel, addsub_hi, addsub_lo, signed_b, signed_a, operand_b, lane_a}),
		.q(in_q)
	);
	assign op_a = in_q[LANE_COUNT*A_W-1:0];
	assign op_b = in_q[LANE_COUNT*(A_W+B_W)-1:LANE_COUNT*A_W];
	assign {op_mode, op_as_hi, op_as_lo, op_sb, op_sa} = in_q[IN_W-1:IN_W-5];

	generate
		for (gi = 0; gi < LANE_COUNT; gi++)
		begin : g_product_only_element
			wire signed [A_W:0] ea = {op_sa & op_a[gi][A_W-1], op_a[gi]};
			wire signed [B_W:0] eb = {op_sb & op_b[gi][B_W-1], op_b[gi]};
			wire signed [P_W+1:0] full = ea * eb;
			assign prod[gi] = full[P_W-1:0];
		end
	endgenerate

	dsp_stage_reg #(.WIDTH(PIPE_W)) u_pipe_stage (
		.clk(clk),
		.rst_b(rst_b),
		.stage_en(pipe_stage_en),
		.clk_sel(pipe_clk_sel),
		.tick_src(tick_src),
		.ce(stage_ce),
		.srst(stage_srst),
		.d({op_mode, op_as_hi, op_as_lo, op_sa | op_sb, prod}),
		.q(pipe_q)
	);
	assign pp_prod = pipe_q[LANE_COUNT*P_W-1:0];
	assign {pp_mode, pp_as_hi, pp_as_lo, pp_sg} = pipe_q[PIPE_W-1:PIPE_W-4];

	assign ext0 = {{2{pp_sg & pp_prod[0][P_W-1]}}, pp_prod[0]};
	assign ext1 = {{2{pp_sg & pp_prod[1][P_W-1]}}, pp_prod[1]};
	assign ext2 = {{2{pp_sg & pp_prod[2][P_W-1]}}, pp_prod[2]};
	assign ext3 = {{2{pp_sg & pp_prod[3][P_W-1]}}, pp_prod[3]};
	assign pair_lo = (pp_as_lo == ADDSUB_ADD) ? ext0 + ext1 : ext0 - ext1;
	assign pair_hi = (pp_as_hi == ADDSUB_ADD) ? ext2 + ext3 : ext2 - ext3;
	// Product-only mode bypasses every adder: lane 0 product straight out.
	assign sum_next = (pp_mode == MODE_FOUR_PRODUCT) ? pair_lo + pair_hi : ext0;

	dsp_stage_reg #(.WIDTH(S_W)) u_out_stage (
		.clk(clk),
		.rst_b(rst_b),
		.stage_en(out_stage_en),
		.clk_sel(out_clk_sel),
		.tick_src(tick_src),
		.ce(stage_ce),
		.srst(stage_srst),
		.d(sum_next),
		.q(out_q)
	);

	// A final flop keeps the top outputs registered whatever stages are bypassed.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			result_reg <= '0;
			serial_a_out_reg <= '0;
		end
		else
		begin
			result_reg <= out_q;
			serial_a_out_reg <= op_a[LANE_COUNT-1];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	product_only_element_only_path_a: assert property (pp_mode == MODE_PRODUCT_ONLY |-> sum_next == ext0)
		else $error("product-only path has adder");
	pair_lo_sum_a: assert property (pp_as_lo |-> pair_lo == S_W'(ext0 - ext1))
		else $error("low pair subtract wrong");
	pair_hi_sum_a: assert property (!pp_as_hi |-> pair_hi == S_W'(ext2 + ext3))
		else $error("high pair add wrong");
	final_sum_a: assert property (pp_mode |-> sum_next == S_W'(pair_lo + pair_hi))
		else $error("final sum wrong");
	bypass_latency_a: assert property (!in_stage_en && !pipe_stage_en && !out_stage_en && mode_sel == MODE_PRODUCT_ONLY
		&& !signed_a && !signed_b && load_sel == LOAD_PARALLEL
		|=> result_reg == S_W'($past(operand_a[0]) * $past(operand_b[0])))
		else $error("bypassed multiply latency wrong");
	out_stage_delay_a: assert property (out_stage_en && stage_ce && !stage_srst && tick_src[out_clk_sel]
		|=> out_q == $past(sum_next))
		else $error("output stage lost result");
	signed_product_a: assert property (op_sa && op_sb |-> $signed(prod[0]) == $signed(op_a[0]) * $signed(op_b[0]))
		else $error("signed product wrong");
	serial_shift_a: assert property (load_sel == LOAD_SERIAL && in_stage_en && !stage_srst && stage_ce
		&& tick_src[in_clk_sel] |=> op_a[1] == $past(op_a[0]) && op_a[0] == $past(serial_a_in))
		else $error("serial load did not shift");
endmodule // dsp_multiply_add_slice
`default_nettype wire

// [verif/fabric_tick_source.sv]
/* Fabric logic model that makes the four clock-source ticks.
 * Assumes the slice samples the ticks on the same clk. */
`default_nettype none
module fabric_tick_source (
	input wire logic clk,
	input wire logic rst_b,
	output logic [3:0] tick
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt_reg;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			cnt_reg <= 2'h0;
		else
			cnt_reg <= cnt_reg + 2'h1;
	// Source 3 never ticks, so a stage put on it must hold.
	assign tick = {1'b0, cnt_reg == 2'h0, cnt_reg[0], 1'b1};
endmodule // fabric_tick_source
`default_nettype wire

// [verif/dsp_multiply_add_slice_bench.sv]
/* Bench for the multiply-add slice: product, four-product, staged and serial cases.
 * Assumes fabric_tick_source supplies the clock-source ticks. */
`default_nettype none
module dsp_multiply_add_slice_bench;
	import dsp_slice_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, mode_sel = 0, load_sel = 0, sgn = 0, add_lo = 0, add_hi = 0;
	logic in_en = 0, pipe_en = 0, out_en = 0, stage_ce = 1, stage_srst = 0;
	logic [1:0] out_sel = 0;
	logic [3:0][17:0] op_a = '0, op_b = '0;
	logic [17:0] ser_in = '0, ser_out;
	logic [37:0] result;
	logic [3:0] tick;
	int err_total = 0, comparisons = 0, cycles = 0;
	always #2.5 clk = ~clk;
	fabric_tick_source fabric_tick_source_inst (.clk(clk), .rst_b(rst_b), .tick(tick));
	dsp_multiply_add_slice dsp_multiply_add_slice_inst (.clk(clk), .rst_b(rst_b), .mode_sel(mode_sel),
		.load_sel(load_sel), .operand_a(op_a), .operand_b(op_b), .serial_a_in(ser_in), .signed_a(sgn),
		.signed_b(sgn), .addsub_lo(add_lo), .addsub_hi(add_hi), .in_stage_en(in_en),
		.pipe_stage_en(pipe_en), .out_stage_en(out_en), .in_clk_sel(2'h0), .pipe_clk_sel(2'h1),
		.out_clk_sel(out_sel), .fabric_clock_source_0(tick[0]), .fabric_clock_source_1(tick[1]),
		.fabric_clock_source_2(tick[2]), .fabric_clock_source_3(tick[3]), .stage_ce(stage_ce),
		.stage_srst(stage_srst), .result_reg(result), .serial_a_out_reg(ser_out));
	task automatic check(input logic [37:0] got, input logic [37:0] want);
		comparisons++;
		if (got !== want)
		begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, want);
		end
	endtask
	function automatic logic [37:0] prod(input logic [17:0] a, input logic [17:0] b, input logic s);
		logic signed [37:0] x, y;
		x = s ? 38'($signed(a)) : 38'(a);
		y = s ? 38'($signed(b)) : 38'(b);
		return x * y;
	endfunction
	task automatic wait_edges(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic test_product;
		op_a <= {18'h0_0009, 18'h0_0005, 18'h0_0007, 18'h3_fffd};
		op_b <= {18'h0_0003, 18'h0_0002, 18'h0_0004, 18'h2_0001};
		for (int s = 0; s < 2; s++)
		begin
			sgn <= s[0];
			wait_edges(1);
			check(result, prod(18'h3_fffd, 18'h2_0001, s[0]));
		end
		$display("product test done");
	endtask
	task automatic test_four;
		logic [37:0] lo, hi;
		mode_sel <= MODE_FOUR_PRODUCT;
		for (int m = 0; m < 4; m++)
		begin
			add_lo <= m[0];
			add_hi <= m[1];
			wait_edges(1);
			lo = m[0] ? prod(op_a[0], op_b[0], 1) - prod(op_a[1], op_b[1], 1) : prod(op_a[0], op_b[0], 1) + prod(op_a[1], op_b[1], 1);
			hi = m[1] ? prod(op_a[2], op_b[2], 1) - prod(op_a[3], op_b[3], 1) : prod(op_a[2], op_b[2], 1) + prod(op_a[3], op_b[3], 1);
			check(result, lo + hi);
		end
		$display("four-product test done");
	endtask
	task automatic test_stages;
		mode_sel <= MODE_PRODUCT_ONLY;
		sgn <= 0;
		in_en <= 1;
		out_en <= 1;
		op_a <= '0;
		wait_edges(4);
		op_a[0] <= 18'h0_0005;
		op_b[0] <= 18'h0_0007;
		wait_edges(1);
		op_a[0] <= 18'h0_0000;
		wait_edges(1);
		// Park the output stage on the idle source before the zero operand reaches it.
		out_sel <= 2'h3;
		wait_edges(1);
		check(result, 38'h00_0000_0023);
		wait_edges(4);
		check(result, 38'h00_0000_0023);
		stage_srst <= 1;
		wait_edges(2);
		check(result, 38'h00_0000_0000);
		stage_srst <= 0;
		stage_ce <= 0;
		out_sel <= 2'h0;
		op_a[0] <= 18'h0_0005;
		wait_edges(3);
		check(result, 38'h00_0000_0000);
		stage_ce <= 1;
		op_a[0] <= 18'h0_0000;
		$display("stage test done");
	endtask
	task automatic test_serial;
		load_sel <= LOAD_SERIAL;
		out_en <= 0;
		for (int i = 1; i < 7; i++)
		begin
			ser_in <= 18'(i * 4369);
			wait_edges(1);
		end
		check(38'(ser_out), 38'd8738);
		$display("serial test done");
	endtask
	task automatic stop_test;
		$display("Counts: comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			err_total++;
			stop_test();
		end
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1;
		wait_edges(1);
		test_product();
		test_four();
		test_stages();
		test_serial();
		stop_test();
	end
endmodule // dsp_multiply_add_slice_bench
`default_nettype wire
